// ### hdl/rtc_i2c_slave.sv
`timescale 1ns/10ps
`default_nettype none
module rtc_i2c_slave #(
  parameter int unsigned REC_CYCLES = rtc_pkg::RECOVERY_DELAY_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output var  logic sda_o,
  output var  logic sda_oe,
  input  wire logic power_fail_i,
  output var  logic write_protect,
  output var  logic clock_hold
);

  // synchronisers and edge history
  logic scl_s1;
  logic scl_s2;
  logic scl_d;
  logic sda_s1;
  logic sda_s2;
  logic sda_d;
  logic pf_s1;
  logic pf_s2;

  // protocol state
  rtc_pkg::rtc_state_t st_reg;
  rtc_pkg::rtc_kind_t  kind_reg;
  logic [3:0]          cnt_reg;
  logic [7:0]          shift_reg;
  logic [7:0]          tx_reg;
  logic                rw_reg;
  logic                acked_reg;
  logic                oe_reg;
  logic                zero_reg;

  // pointer, memory and protection
  logic [14:0] ptr_reg;
  logic [7:0]  rd_data_reg;
  logic [7:0]  mem [0:(1 << rtc_pkg::ADDR_W) - 1];
  logic [15:0] rec_cnt_reg;
  logic        wp_reg;
  logic        hold_reg;

  // decoded events
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic byte_done;
  logic addr_hit;
  logic ptr_is_rsv;
  logic ptr_is_clock;
  logic data_ack;
  logic read_ack;

  // two flops per pin before any logic looks at it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d  <= 1'b1;
    end else begin
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
    end
  end

  // power fail level, held asserted at reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pf_s1 <= 1'b1;
      pf_s2 <= 1'b1;
    end else begin
      pf_s1 <= power_fail_i;
      pf_s2 <= pf_s1;
    end
  end

  // bus conditions from the sampled lines
  assign scl_rise  = scl_s2 & ~scl_d;
  assign scl_fall  = ~scl_s2 & scl_d;
  assign start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_det  = scl_s2 & scl_d & ~sda_d & sda_s2;

  // byte and acknowledge events
  assign byte_done = scl_fall && (st_reg == rtc_pkg::RTC_RX)
                     && (cnt_reg == rtc_pkg::BYTE_BITS);
  assign addr_hit  = shift_reg[7:1] == rtc_pkg::SLAVE_ADDR;
  assign data_ack  = scl_rise && (st_reg == rtc_pkg::RTC_ACK)
                     && (kind_reg == rtc_pkg::RTC_K_DATA);
  assign read_ack  = scl_rise && (st_reg == rtc_pkg::RTC_MACK)
                     && !sda_s2;

  // address decode of the map
  assign ptr_is_rsv   = (ptr_reg >= rtc_pkg::RSV_FIRST)
                        && (ptr_reg <= rtc_pkg::RSV_LAST);
  assign ptr_is_clock = (ptr_reg >= rtc_pkg::SEC_OFS)
                        && (ptr_reg <= rtc_pkg::YEAR_OFS);

  // recovery counter keeps the part deselected after supply returns
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rec_cnt_reg <= 16'h0000;
    end else if (pf_s2) begin
      rec_cnt_reg <= 16'(REC_CYCLES);
    end else if (rec_cnt_reg != 16'h0000) begin
      rec_cnt_reg <= rec_cnt_reg - 16'h0001;
    end
  end

  // protection spans the fail and the recovery
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg <= 1'b1;
    end else begin
      wp_reg <= pf_s2 | (rec_cnt_reg != 16'h0000);
    end
  end

  // main protocol machine
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg    <= rtc_pkg::RTC_IDLE;
      kind_reg  <= rtc_pkg::RTC_K_ADDR;
      cnt_reg   <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg    <= 8'h00;
      rw_reg    <= 1'b0;
      acked_reg <= 1'b0;
      oe_reg    <= 1'b0;
    end else if (pf_s2 || wp_reg) begin
      // abort anything in flight, ignore the bus
      st_reg <= rtc_pkg::RTC_IDLE;
      oe_reg <= 1'b0;
    end else if (stop_det) begin
      st_reg <= rtc_pkg::RTC_IDLE;
      oe_reg <= 1'b0;
    end else if (start_det) begin
      // repeated start is taken from any state
      st_reg   <= rtc_pkg::RTC_RX;
      kind_reg <= rtc_pkg::RTC_K_ADDR;
      cnt_reg  <= 4'h0;
      oe_reg   <= 1'b0;
    end else begin
      unique case (st_reg)
        rtc_pkg::RTC_IDLE: begin
          oe_reg <= 1'b0;
        end
        rtc_pkg::RTC_RX: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_s2};
            cnt_reg   <= cnt_reg + 4'h1;
          end else if (byte_done) begin
            if (kind_reg == rtc_pkg::RTC_K_ADDR && !addr_hit) begin
              st_reg <= rtc_pkg::RTC_IDLE;
            end else begin
              // pull low through the ninth pulse
              st_reg <= rtc_pkg::RTC_ACK;
              oe_reg <= 1'b1;
              if (kind_reg == rtc_pkg::RTC_K_ADDR) begin
                rw_reg <= shift_reg[0];
              end
            end
          end
        end
        rtc_pkg::RTC_ACK: begin
          if (scl_fall) begin
            cnt_reg <= 4'h0;
            if (kind_reg == rtc_pkg::RTC_K_ADDR && rw_reg) begin
              // first read byte, msb out on this fall
              st_reg  <= rtc_pkg::RTC_TX;
              tx_reg  <= rd_data_reg;
              oe_reg  <= ~rd_data_reg[7];
              cnt_reg <= 4'h1;
            end else begin
              st_reg <= rtc_pkg::RTC_RX;
              oe_reg <= 1'b0;
              unique case (kind_reg)
                rtc_pkg::RTC_K_ADDR: kind_reg <= rtc_pkg::RTC_K_PHI;
                rtc_pkg::RTC_K_PHI:  kind_reg <= rtc_pkg::RTC_K_PLO;
                rtc_pkg::RTC_K_PLO:  kind_reg <= rtc_pkg::RTC_K_DATA;
                rtc_pkg::RTC_K_DATA: kind_reg <= rtc_pkg::RTC_K_DATA;
              endcase
            end
          end
        end
        rtc_pkg::RTC_TX: begin
          // change data only after the clock has fallen
          if (scl_fall) begin
            if (cnt_reg == rtc_pkg::BYTE_BITS) begin
              st_reg <= rtc_pkg::RTC_MACK;
              oe_reg <= 1'b0;
            end else begin
              oe_reg  <= ~tx_reg[6];
              tx_reg  <= {tx_reg[6:0], 1'b0};
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
        end
        rtc_pkg::RTC_MACK: begin
          if (scl_rise) begin
            acked_reg <= !sda_s2;
          end else if (scl_fall) begin
            if (acked_reg) begin
              st_reg  <= rtc_pkg::RTC_TX;
              tx_reg  <= rd_data_reg;
              oe_reg  <= ~rd_data_reg[7];
              cnt_reg <= 4'h1;
            end else begin
              // nack: leave the line high for the stop
              st_reg <= rtc_pkg::RTC_IDLE;
              oe_reg <= 1'b0;
            end
          end
        end
        default: st_reg <= rtc_pkg::RTC_IDLE; // spare codes fall back to idle
      endcase
    end
  end

  // pointer: loaded by pointer bytes, bumped on acknowledge clocks
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_reg <= rtc_pkg::PTR_RESET;
    end else if (pf_s2) begin
      ptr_reg <= rtc_pkg::PTR_RESET;
    end else if (wp_reg || stop_det || start_det) begin
      ptr_reg <= ptr_reg;
    end else if (byte_done && kind_reg == rtc_pkg::RTC_K_PHI) begin
      ptr_reg[14:8] <= shift_reg[6:0];
    end else if (byte_done && kind_reg == rtc_pkg::RTC_K_PLO) begin
      ptr_reg[7:0] <= shift_reg;
    end else if (data_ack || read_ack) begin
      ptr_reg <= ptr_reg + 15'h0001;
    end
  end

  // storage; reserved bytes drop writes and read as zero
  always_ff @(posedge sys_clk) begin
    if (byte_done && kind_reg == rtc_pkg::RTC_K_DATA && !wp_reg
        && !pf_s2 && !stop_det && !start_det && !ptr_is_rsv) begin
      mem[ptr_reg] <= shift_reg;
    end
  end

  // read data follows the pointer one cycle later, long before use
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_reg <= 8'h00;
    end else if (ptr_is_rsv) begin
      rd_data_reg <= rtc_pkg::RSV_READ;
    end else begin
      rd_data_reg <= mem[ptr_reg];
    end
  end

  // clock update hold while reading a clock register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_reg <= 1'b0;
    end else begin
      hold_reg <= ptr_is_clock && ((st_reg == rtc_pkg::RTC_TX)
                  || (st_reg == rtc_pkg::RTC_MACK));
    end
  end

  // open drain: output level is always low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_reg <= 1'b0;
    end else begin
      zero_reg <= 1'b0;
    end
  end

  assign sda_o         = zero_reg;
  assign sda_oe        = oe_reg;
  assign write_protect = wp_reg;
  assign clock_hold    = hold_reg;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  data_ack_drive_a: assert property (
    byte_done && !wp_reg && !pf_s2 && kind_reg != rtc_pkg::RTC_K_ADDR
    |=> oe_reg && st_reg == rtc_pkg::RTC_ACK)
    else $error("no acknowledge after received byte");

  addr_mismatch_a: assert property (
    byte_done && !wp_reg && !pf_s2 && kind_reg == rtc_pkg::RTC_K_ADDR
    && !addr_hit |=> !oe_reg && st_reg == rtc_pkg::RTC_IDLE)
    else $error("foreign address was acknowledged");

  stop_idle_a: assert property (
    stop_det && !wp_reg && !pf_s2
    |=> st_reg == rtc_pkg::RTC_IDLE && !oe_reg)
    else $error("stop did not end transfer");

  start_addr_a: assert property (
    start_det && !wp_reg && !pf_s2 |=> st_reg == rtc_pkg::RTC_RX
    && kind_reg == rtc_pkg::RTC_K_ADDR && cnt_reg == 4'h0)
    else $error("start not taken");

  pf_clear_a: assert property (
    pf_s2 |=> ptr_reg == rtc_pkg::PTR_RESET
    && st_reg == rtc_pkg::RTC_IDLE)
    else $error("power fail did not abort");

  pf_ignore_a: assert property (
    wp_reg |-> st_reg == rtc_pkg::RTC_IDLE && !oe_reg)
    else $error("bus active while protected");

  rec_hold_a: assert property (
    $fell(pf_s2) |=> wp_reg [*8])
    else $error("protection dropped before recovery");

  ptr_inc_a: assert property (
    (data_ack || read_ack) && !wp_reg && !pf_s2
    |=> ptr_reg == 15'($past(ptr_reg) + 15'h0001))
    else $error("pointer did not advance");

  tx_change_a: assert property (
    st_reg == rtc_pkg::RTC_TX && $changed(oe_reg) |-> $past(scl_fall))
    else $error("data changed outside clock low");

  mack_release_a: assert property (
    st_reg == rtc_pkg::RTC_MACK |-> !oe_reg)
    else $error("line held during master acknowledge");

  ack_low_a: assert property (
    st_reg == rtc_pkg::RTC_ACK |-> oe_reg && !sda_o)
    else $error("acknowledge not pulled low");

  ptr_wrap_a: assert property (
    (data_ack || read_ack) && !wp_reg && !pf_s2
    && ptr_reg == rtc_pkg::YEAR_OFS |=> ptr_reg == rtc_pkg::PTR_RESET)
    else $error("pointer did not wrap to zero");

  fail_protect_a: assert property (
    pf_s2 |=> wp_reg)
    else $error("supply fail left bus unprotected");

  clock_hold_a: assert property (
    ptr_is_clock && st_reg == rtc_pkg::RTC_TX |=> hold_reg)
    else $error("clock update not held during read");

  idle_release_a: assert property (
    st_reg == rtc_pkg::RTC_IDLE |-> !oe_reg && !sda_o)
    else $error("data line driven while idle");

  write_cov_c: cover property (data_ack);
  read_cov_c: cover property (read_ack);
  nack_end_c: cover property (
    st_reg == rtc_pkg::RTC_MACK && scl_fall && !acked_reg);
  recover_c: cover property ($fell(wp_reg));
  wrap_cov_c: cover property (data_ack && ptr_reg == rtc_pkg::YEAR_OFS);

endmodule
`default_nettype wire

// ### include/rtc_pkg.sv
`default_nettype none
package rtc_pkg;

  // bus address, write form D0h shifted right
  localparam logic [6:0] SLAVE_ADDR = 7'h68;

  // memory map
  localparam int         ADDR_W     = 15;
  localparam logic [14:0] RAM_LAST  = 15'h7FEF;
  localparam logic [14:0] RSV_FIRST = 15'h7FF0;
  localparam logic [14:0] RSV_LAST  = 15'h7FF6;
  localparam logic [14:0] SUBSEC_OFS = 15'h7FF7;
  localparam logic [14:0] CTRL_OFS  = 15'h7FF8;
  localparam logic [14:0] SEC_OFS   = 15'h7FF9;
  localparam logic [14:0] MIN_OFS   = 15'h7FFA;
  localparam logic [14:0] HOUR_OFS  = 15'h7FFB;
  localparam logic [14:0] DAY_OFS   = 15'h7FFC;
  localparam logic [14:0] DATE_OFS  = 15'h7FFD;
  localparam logic [14:0] MONTH_OFS = 15'h7FFE;
  localparam logic [14:0] YEAR_OFS  = 15'h7FFF;

  // reset value, reserved read value and bits per byte
  localparam logic [14:0] PTR_RESET = 15'h0000;
  localparam logic [7:0]  RSV_READ  = 8'h00;
  localparam logic [3:0]  BYTE_BITS = 4'h8;

  // recovery delay after supply returns
  localparam int CLK_PERIOD_NS     = 8;
  localparam int RECOVERY_DELAY_NS = 1000;
  localparam int RECOVERY_DELAY_CYCLES =
    (RECOVERY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    RTC_IDLE, RTC_RX, RTC_ACK, RTC_TX, RTC_MACK
  } rtc_state_t;

  typedef enum logic [1:0] {
    RTC_K_ADDR, RTC_K_PHI, RTC_K_PLO, RTC_K_DATA
  } rtc_kind_t;

endpackage
`default_nettype wire

// ### verification/rtc_bus_master.sv
`timescale 1ns/10ps
`default_nettype none
module rtc_bus_master (
  output var  logic scl,
  output var  logic sda_low,
  input  wire logic sda
);
  // bus idle: clock high, data released, until a frame opens
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // one bit slot; data only moves while clock is low
  task automatic bit_io(input logic b, output logic s);
    #31.25 sda_low = ~b;
    #31.25 scl = 1'b1;
    #31.25 s = sda;
    #31.25 scl = 1'b0;
  endtask

  // works from idle and as a repeated start
  task automatic start();
    #31.25 sda_low = 1'b0;
    #31.25 scl = 1'b1;
    #62.5 sda_low = 1'b1;
    #62.5 scl = 1'b0;
  endtask

  // clock parks high afterwards, as an idle bus
  task automatic stop();
    #31.25 sda_low = 1'b1;
    #31.25 scl = 1'b1;
    #62.5 sda_low = 1'b0;
    #125;
  endtask

  // eight bits msb first, then release for the slave's answer
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // released bits sampled msb first, then our own ack or nack
  task automatic rbyte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(~ack, s);
  endtask
endmodule
`default_nettype wire

// ### verification/test_serial_rtc_sram_i2c_slave.sv
`timescale 1ns/10ps
`default_nettype none
module test_serial_rtc_sram_i2c_slave;
  // short recovery keeps the run brief
  localparam int REC = 16;
  logic sys_clk;
  logic rst_n;
  logic power_fail_i;
  logic scl;
  logic m_low;
  wire logic sda;
  logic sda_o;
  logic sda_oe;
  logic write_protect;
  logic clock_hold;
  int   n_fail = 0;
  int   checks = 0;
  int   cycles = 0;

  // pulled-up wire: any party pulling low wins
  assign sda = ~(m_low | (sda_oe & ~sda_o));

  rtc_i2c_slave #(.REC_CYCLES(REC)) dut (
    .sys_clk       (sys_clk),
    .rst_n         (rst_n),
    .scl_i         (scl),
    .sda_i         (sda),
    .sda_o         (sda_o),
    .sda_oe        (sda_oe),
    .power_fail_i  (power_fail_i),
    .write_protect (write_protect),
    .clock_hold    (clock_hold)
  );

  rtc_bus_master m (
    .scl     (scl),
    .sda_low (m_low),
    .sda     (sda)
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // hang guard, far above the expected run length
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (n_fail == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  // byte from master, slave answer compared
  task automatic tx(input logic [7:0] b, input logic e);
    logic k;
    m.wbyte(b, k);
    chk("ack", {7'h00, e}, {7'h00, k});
  endtask

  task automatic rd(input logic [7:0] e, input logic ack);
    logic [7:0] b;
    m.rbyte(ack, b);
    chk("read data", e, b);
  endtask

  // start, write address, pointer high then low
  task automatic setp(input logic [15:0] p);
    m.start();
    tx(8'hD0, 1'b1);
    tx(p[15:8], 1'b1);
    tx(p[7:0], 1'b1);
  endtask

  task automatic wait_wp(output int n);
    n = 0;
    while (write_protect !== 1'b0 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    // step off the clock grid so bus edges never meet a sampling edge
    #0.13;
  endtask

  // ram top, reserved write dropped, sequential read ends on nack
  task automatic t_ram_edge();
    setp(16'hFFEE);
    tx(8'hA5, 1'b1);
    tx(8'h5A, 1'b1);
    tx(8'hC3, 1'b1);
    m.stop();
    setp(16'h7FEE);
    m.start();
    tx(8'hD1, 1'b1);
    rd(8'hA5, 1'b1);
    rd(8'h5A, 1'b1);
    rd(8'h00, 1'b0);
    chk("line after nack", 8'h01, {7'h00, sda});
    m.stop();
  endtask

  // clock bytes, wrap at top, then a read without pointer load
  task automatic t_wrap();
    setp(16'h7FFE);
    tx(8'h66, 1'b1);
    tx(8'h77, 1'b1);
    tx(8'h88, 1'b1);
    m.stop();
    setp(16'h7FFE);
    m.start();
    tx(8'hD1, 1'b1);
    // first bit is already out well inside this low phase
    #50;
    chk("clock hold", 8'h01, {7'h00, clock_hold});
    rd(8'h66, 1'b1);
    rd(8'h77, 1'b1);
    chk("hold after wrap", 8'h00, {7'h00, clock_hold});
    rd(8'h88, 1'b0);
    m.stop();
    m.start();
    tx(8'hD1, 1'b1);
    rd(8'h88, 1'b0);
    m.stop();
  endtask

  // near misses: wrong bit order, other device, lowest address bit flipped
  task automatic t_bad_addr();
    logic [7:0] bad [3] = '{8'h0B, 8'hA0, 8'hD2};
    foreach (bad[i]) begin
      m.start();
      tx(bad[i], 1'b0);
      m.stop();
    end
  endtask

  // supply fails mid-transfer, bus ignored, pointer cleared
  task automatic t_power();
    int n;
    setp(16'h0010);
    @(negedge sys_clk);
    power_fail_i = 1'b1;
    repeat (8) @(negedge sys_clk);
    chk("protect", 8'h01, {7'h00, write_protect});
    #0.13;
    m.start();
    tx(8'hD0, 1'b0);
    tx(8'h00, 1'b0);
    tx(8'h00, 1'b0);
    tx(8'h99, 1'b0);
    m.stop();
    @(negedge sys_clk);
    power_fail_i = 1'b0;
    wait_wp(n);
    chk("recovery", 8'h01, {7'h00, n >= REC && n <= REC + 8});
    m.start();
    tx(8'hD1, 1'b1);
    rd(8'h88, 1'b0);
    m.stop();
  endtask

  initial begin
    int n;
    rst_n = 1'b0;
    power_fail_i = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk("reset protect", 8'h01, {7'h00, write_protect});
    chk("reset drive", 8'h00, {7'h00, sda_oe});
    chk("reset level", 8'h00, {7'h00, sda_o});
    rst_n = 1'b1;
    wait_wp(n);
    chk("start recovery", 8'h01, {7'h00, n >= REC && n <= REC + 8});
    t_ram_edge();
    t_wrap();
    t_bad_addr();
    t_power();
    stop_test();
  end
endmodule
`default_nettype wire
